// file: dac_front_end.sv
`timescale 1ns/1ps
`default_nettype none

module dac_front_end
  import dac_front_pkg::*;
#(
  parameter int WIDTH = `DATA_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] sample_data,
  input  wire logic             sample_valid,
  output logic                  sample_ready,
  input  wire logic             mode_or_reset_pin,
  input  wire logic             powerdown_or_select_pin,
  input  wire logic             clock_type_or_serial_clock_pin,
  input  wire logic             format_or_serial_data_pin_in,
  output logic                  format_or_serial_data_pin_out,
  output logic                  format_or_serial_data_pin_oe,
  output logic [WIDTH-1:0]      true_current_output,
  output logic [WIDTH-1:0]      complementary_current_output,
  output logic                  conversion_strobe,
  output logic                  clock_receiver_select,
  output logic                  powerdown,
  output logic                  twos_complement,
  output logic                  serial_mode
);

  typedef struct packed {
    pin_set_type                   sync1;
    pin_set_type                   sync2;
    logic                          sclk_prev;
    logic [`FRAME_BITS-1:0]        shift;
    logic [`CNT_W-1:0]             count;
    logic                          rd_cmd;
    logic [`ADDR_W-1:0]            addr;
    logic [`CFG_W-1:0]             cfg;
    logic                          sdo;
    logic                          sdo_oe;
    logic [WIDTH-1:0]              code_true;
    logic [WIDTH-1:0]              code_comp;
    logic                          strobe;
    logic                          pd;
    logic                          twos;
    logic                          diff;
    mode_type                      mode;
  } front_state_type;

  front_state_type        state_reg;
  front_state_type        state_next;
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   cs_n;
  logic [`FRAME_BITS-1:0] shift_in;
  logic [`CFG_W-1:0]      rd_word;
  logic [WIDTH-1:0]       code;

  sample_stream_if #(.WIDTH(WIDTH)) in_if ();
  sample_stream_if #(.WIDTH(WIDTH)) out_if ();

  // Host samples enter the FIFO
  assign in_if.valid  = sample_valid;
  assign in_if.data   = sample_data;
  assign sample_ready = in_if.ready;
  // Power-down stalls the drain, so the FIFO fills and holds off the host
  assign out_if.ready = !state_reg.pd;

  sample_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) fifo_inst (
    .clk  (clk),
    .rstn (rstn),
    .push (in_if.sink),
    .pop  (out_if.source)
  );

  // Outputs from the state register
  assign format_or_serial_data_pin_out = state_reg.sdo;
  assign format_or_serial_data_pin_oe  = state_reg.sdo_oe;
  assign true_current_output           = state_reg.code_true;
  assign complementary_current_output  = state_reg.code_comp;
  assign conversion_strobe             = state_reg.strobe;
  assign clock_receiver_select         = state_reg.diff;
  assign powerdown                     = state_reg.pd;
  assign twos_complement               = state_reg.twos;
  assign serial_mode                   = (state_reg.mode == MODE_SERIAL);

  // Next-state logic: pin sync, serial port, settings, sample path
  always_comb begin
    state_next           = state_reg;
    state_next.sync1     = '{mode_pin:     mode_or_reset_pin,
                             pd_cs_pin:    powerdown_or_select_pin,
                             clk_sclk_pin: clock_type_or_serial_clock_pin,
                             sdio_pin:     format_or_serial_data_pin_in};
    state_next.sync2     = state_reg.sync1;
    state_next.sclk_prev = state_reg.sync2.clk_sclk_pin;
    sclk_rise = state_reg.sync2.clk_sclk_pin && !state_reg.sclk_prev;
    sclk_fall = !state_reg.sync2.clk_sclk_pin && state_reg.sclk_prev;
    shift_in  = {state_reg.shift[`FRAME_BITS-2:0],
                 state_reg.sync2.sdio_pin};
    rd_word   = (state_reg.addr == `ADDR_CTRL) ? state_reg.cfg : `CFG_ZERO;
    code      = '0;

    // mode from the mode pin level
    state_next.mode = state_reg.sync2.mode_pin ? MODE_STRAP : MODE_SERIAL;

    // chip select only meaningful in serial mode
    cs_n = state_reg.sync2.pd_cs_pin || (state_reg.mode != MODE_SERIAL);

    if (cs_n) begin
      state_next.count  = `CNT_ZERO;
      state_next.sdo_oe = 1'b0;
    end else if (sclk_rise && state_reg.count <= `CNT_LAST) begin
      state_next.shift = shift_in;
      state_next.count = state_reg.count + `CNT_ONE;
      if (state_reg.count == `CNT_W'(`CMD_BITS - 1)) begin
        state_next.rd_cmd = shift_in[`CMD_RD_BIT];
        state_next.addr   = shift_in[`ADDR_W-1:0];
      end
      if (state_reg.count == `CNT_LAST && !state_reg.rd_cmd &&
          state_reg.addr == `ADDR_CTRL) begin
        state_next.cfg = shift_in[`CFG_W-1:0];
      end
    end else if (sclk_fall && state_reg.rd_cmd &&
                 state_reg.count >= `CNT_W'(`CMD_BITS) &&
                 state_reg.count <= `CNT_LAST) begin
      // read data driven out on the shared data pin
      state_next.sdo_oe = 1'b1;
      state_next.sdo    = rd_word[`DATA_IDX_TOP -
                          state_reg.count[`DATA_IDX_W-1:0]];
    end
    // mode pin high restores defaults, over any write
    if (state_reg.sync2.mode_pin) begin
      state_next.cfg = `CFG_DEFAULT;
    end

    // Effective settings per mode
    case (state_reg.mode)
      MODE_STRAP: begin
        state_next.pd   = state_reg.sync2.pd_cs_pin;
        state_next.twos = state_reg.sync2.sdio_pin;
        state_next.diff = state_reg.sync2.clk_sclk_pin;
      end
      MODE_SERIAL: begin
        state_next.pd   = state_reg.cfg[`CFG_BIT_PD];
        state_next.twos = state_reg.cfg[`CFG_BIT_TWOS];
        state_next.diff = state_reg.cfg[`CFG_BIT_DIFF];
      end
      default: begin
        state_next.pd = 1'b1;
      end
    endcase

    // Sample conversion to offset binary
    state_next.strobe = out_if.valid && out_if.ready;
    if (out_if.valid && out_if.ready) begin
      code = out_if.data;
      code[WIDTH-1] = out_if.data[WIDTH-1] ^ state_reg.twos;
      // all ones full scale on true output
      state_next.code_true = code;
      // all zeros full scale on complementary output
      state_next.code_comp = ~code;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

// file: dac_front_cfg.svh
`ifndef DAC_FRONT_CFG_SVH
`define DAC_FRONT_CFG_SVH

// Sample word width and FIFO depth
`define DATA_W        14
`define FIFO_DEPTH    8

// Serial frame layout: command byte then data byte, MSB first
`define FRAME_BITS    16
`define CMD_BITS      8
`define CNT_W         5
`define CNT_ZERO      5'h00
`define CNT_ONE       5'h01
`define CNT_LAST      5'h0F
`define CMD_RD_BIT    7
`define DATA_IDX_W    3
`define DATA_IDX_TOP  3'h7

// Configuration register address, fields and default
`define ADDR_W        7
`define ADDR_CTRL     7'h00
`define CFG_W         8
`define CFG_DEFAULT   8'h00
`define CFG_ZERO      8'h00
`define CFG_BIT_PD    0
`define CFG_BIT_TWOS  1
`define CFG_BIT_DIFF  2

`endif

// file: dac_front_pkg.sv
`include "dac_front_cfg.svh"

package dac_front_pkg;

  // Configuration source
  typedef enum logic {
    MODE_STRAP,
    MODE_SERIAL
  } mode_type;

  // Two-stage synchroniser for the four shared pins
  typedef struct packed {
    logic mode_pin;
    logic pd_cs_pin;
    logic clk_sclk_pin;
    logic sdio_pin;
  } pin_set_type;

endpackage

// file: sample_stream_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sample_stream_if #(
  parameter int WIDTH = 14
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

`default_nettype wire

// file: sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  sample_stream_if.sink     push,
  sample_stream_if.source   pop
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [CW-1:0]               count;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } fifo_state_type;

  fifo_state_type state_reg;
  fifo_state_type state_next;
  logic           do_write;
  logic           do_load;

  // Handshakes come straight from registered state
  assign push.ready = (state_reg.count != FULL_CNT);
  assign pop.valid  = state_reg.out_valid;
  assign pop.data   = state_reg.out_data;

  // Storage array plus a registered output stage
  always_comb begin
    state_next = state_reg;
    do_write   = push.valid && push.ready;
    do_load    = (!state_reg.out_valid || pop.ready) &&
                 (state_reg.count != '0);
    if (pop.ready && state_reg.out_valid) begin
      state_next.out_valid = 1'b0;
    end
    if (do_write) begin
      state_next.mem[state_reg.wptr] = push.data;
      state_next.wptr = (state_reg.wptr == LAST_PTR) ? '0 :
                        state_reg.wptr + 1'b1;
    end
    if (do_load) begin
      state_next.out_data  = state_reg.mem[state_reg.rptr];
      state_next.out_valid = 1'b1;
      state_next.rptr = (state_reg.rptr == LAST_PTR) ? '0 :
                        state_reg.rptr + 1'b1;
    end
    if (do_write && !do_load) begin
      state_next.count = state_reg.count + 1'b1;
    end else if (!do_write && do_load) begin
      state_next.count = state_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

// file: dac_front_end_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dac_front_end_asserts #(
  parameter int WIDTH = 14
) (
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             mode_or_reset_pin,
  input wire logic             powerdown_or_select_pin,
  input wire logic             clock_type_or_serial_clock_pin,
  input wire logic             format_or_serial_data_pin_in,
  input wire logic             format_or_serial_data_pin_oe,
  input wire logic [WIDTH-1:0] true_current_output,
  input wire logic [WIDTH-1:0] complementary_current_output,
  input wire logic             conversion_strobe,
  input wire logic             clock_receiver_select,
  input wire logic             powerdown,
  input wire logic             twos_complement,
  input wire logic             serial_mode
);
  // Short aliases for the shared pins and settings
  wire logic       m   = mode_or_reset_pin;
  wire logic       sel = powerdown_or_select_pin;
  wire logic       ck  = clock_type_or_serial_clock_pin;
  wire logic       fm  = format_or_serial_data_pin_in;
  wire logic       oe  = format_or_serial_data_pin_oe;
  wire logic [2:0] st  = {powerdown, clock_receiver_select, twos_complement};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Settled strap pins appear three edges later
  chk_strap_pd: assert property (
    (m && $stable(sel))[*4] |=> powerdown == $past(sel)) else $error("pd");
  chk_strap_coding: assert property (
    (m && $stable(fm))[*4] |=> twos_complement == $past(fm)) else $error("fm");
  chk_strap_clock: assert property (
    (m && $stable(ck))[*4] |=> clock_receiver_select == $past(ck))
    else $error("ck");
  chk_mode_select: assert property (
    $stable(m)[*4] |=> serial_mode == !$past(m)) else $error("mode");
  chk_serial_hold: assert property (
    (!m && sel)[*6] |=> $stable(st)) else $error("serial hold");
  chk_mode_pulse: assert property (
    m[*4] ##1 (!m)[*6] |=> st == 3'h0) else $error("cfg default");
  chk_oe_idle: assert property (
    sel[*5] |=> !oe) else $error("oe");
  chk_code_pair: assert property (
    conversion_strobe |-> complementary_current_output ==
    ~true_current_output) else $error("pair");
  chk_code_hold: assert property (
    !conversion_strobe |-> $stable(true_current_output)) else $error("hold");
  cover property (conversion_strobe);
  cover property (oe);
  cover property (serial_mode && st == 3'h3);
endmodule
bind dac_front_end dac_front_end_asserts #(.WIDTH(WIDTH))
  dac_front_end_asserts_i (.*);
`default_nettype wire

// file: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk,
  input  wire logic        ready,
  input  wire logic        sdo,
  input  wire logic        sdo_oe,
  output logic [13:0]      data,
  output logic             valid,
  output logic             mode_pin,
  output logic             sel_pin,
  output logic             ck_pin,
  output logic             sdio
);
  logic drv;
  int   stalls = 0;
  assign sdio = sdo_oe ? sdo : drv;
  initial {data, valid, mode_pin, sel_pin, ck_pin, drv} = 19'h08;
  // One word, held until taken, then one idle cycle
  task automatic push(input logic [13:0] w);
    data = w;
    valid = 1'b1;
    for (int n = 0; n < 40 && !ready; n++) @(negedge clk);
    if (!ready) begin
      stalls++;
      $display("mismatch at %0t: push stalled", $time);
    end
    @(negedge clk);
    valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic frame(input logic [15:0] w, output logic [7:0] rd);
    sel_pin = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      ck_pin = 1'b0;
      drv = (w[15] && i < 8) ? ~drv : w[i];
      repeat (4) @(negedge clk);
      if (i < 8) rd[i] = sdio;
      ck_pin = 1'b1;
      repeat (4) @(negedge clk);
    end
    sel_pin = 1'b1;
    repeat (4) @(negedge clk);
    ck_pin = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dac_front_end_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dac_front_end_tb;
  import dac_front_pkg::*;
  logic        clk, rstn, rdy, sdo, oe, stb, vld, md, sel, ck, sd;
  logic        diff, pd, twos, smode;
  logic [13:0] dat, tru, cmp;
  logic [7:0]  rd;
  int          bad_count, samples_checked, n;
  dac_front_end dac_front_end_i (.clk(clk), .rstn(rstn), .sample_data(dat),
    .sample_valid(vld), .sample_ready(rdy), .mode_or_reset_pin(md),
    .powerdown_or_select_pin(sel), .clock_type_or_serial_clock_pin(ck),
    .format_or_serial_data_pin_in(sd), .format_or_serial_data_pin_out(sdo),
    .format_or_serial_data_pin_oe(oe), .true_current_output(tru),
    .complementary_current_output(cmp), .conversion_strobe(stb),
    .clock_receiver_select(diff), .powerdown(pd), .twos_complement(twos),
    .serial_mode(smode));
  host_model host_model_i (.clk(clk), .ready(rdy), .sdo(sdo), .sdo_oe(oe),
    .data(dat), .valid(vld), .mode_pin(md), .sel_pin(sel), .ck_pin(ck),
    .sdio(sd));
  // Clock source
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compare and count
  task automatic eq(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    bad_count += host_model_i.stalls;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Strap levels {power-down, clock type, coding}
  task automatic strap(input logic [2:0] s);
    {host_model_i.sel_pin, host_model_i.ck_pin, host_model_i.drv} = s;
    repeat (5) @(negedge clk);
  endtask
  // Send one word and compare the codes it produces
  task automatic conv(input logic [13:0] w, input logic [13:0] exp);
    host_model_i.push(w);
    for (int k = 0; k < 20 && !stb; k++) @(negedge clk);
    if (!stb) begin
      bad_count++;
      $display("mismatch at %0t: no conversion strobe", $time);
    end
    eq(tru, exp);
    eq(cmp, ~exp);
  endtask
  // Main sequence
  initial begin
    rstn = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(negedge clk);
    eq({smode, pd, diff, twos, oe}, 14'h0000);
    rstn = 1'b1;
    for (int s = 0; s < 8; s++) begin
      strap(s[2:0]);
      eq({smode, pd, diff, twos}, {1'b0, s[2:0]});
    end
    strap(3'h0);
    conv(14'h3FFF, 14'h3FFF);
    conv(14'h0000, 14'h0000);
    conv(14'h2001, 14'h2001);
    strap(3'h1);
    conv(14'h2001, 14'h0001);
    // Power-down stalls the drain
    strap(3'h4);
    n = 0;
    for (int k = 1; k < 12; k++)
      if (rdy) begin
        host_model_i.push(k[13:0]);
        n++;
      end
    eq(n[13:0], 14'h0009);
    host_model_i.sel_pin = 1'b0;
    n = 0;
    for (int k = 0; k < 30; k++) begin
      @(negedge clk);
      if (stb) n++;
    end
    eq(n[13:0], 14'h0009);
    eq(tru, 14'h0009);
    // Serial configuration
    host_model_i.mode_pin = 1'b0;
    host_model_i.sel_pin = 1'b1;
    repeat (6) @(negedge clk);
    host_model_i.frame(16'h0006, rd);
    repeat (4) @(negedge clk);
    eq({smode, pd, diff, twos}, 14'h000B);
    host_model_i.frame(16'h8000, rd);
    eq(rd, 8'h06);
    host_model_i.frame(16'h0501, rd);
    host_model_i.frame(16'h8500, rd);
    eq(rd, 8'h00);
    eq({pd, diff, twos}, 14'h0003);
    // Mode pulse restores defaults
    host_model_i.mode_pin = 1'b1;
    repeat (5) @(negedge clk);
    host_model_i.mode_pin = 1'b0;
    repeat (6) @(negedge clk);
    eq({smode, pd, diff, twos}, 14'h0008);
    print_verdict;
  end
endmodule
`default_nettype wire
